// ===== rtl/iicc_map.svh
// Register map, field positions and reset values of the colour config block
`ifndef IICC_MAP_SVH
`define IICC_MAP_SVH

`define IICC_OFS_FORMAT 8'h04
`define IICC_OFS_CONV 8'h14
`define IICC_OFS_CTRL 8'h20
`define IICC_OFS_STATUS 8'h24

`define IICC_RST_FORMAT 32'h0000_0000
`define IICC_RST_CONV 32'h0000_7102
`define IICC_RST_CTRL 32'h0000_0000
`define IICC_MASK_FORMAT 32'hf7ff_ffff
`define IICC_MASK_CONV 32'h0000_71ff
`define IICC_MASK_CTRL 32'h0000_0001

`define IICC_F_ORDER 31:30
`define IICC_F_SWAP 29:28
`define IICC_F_WIDTH 26:16
`define IICC_F_HEIGHT 10:0
`define IICC_B_RSVD 27
`define IICC_B_RGBSEL 12
`define IICC_B_CBOFF 14
`define IICC_B_CROFF 13
`define IICC_B_YOFF 12
`define IICC_F_C4 8:0
`define IICC_B_RGB888 0
`define IICC_B_OVF 16
`define IICC_B_OUTV 17

`define IICC_CHROMA_OFS 12'h010
`define IICC_LUMA_OFS 12'h080
`define IICC_C4_SHIFT 7
`define IICC_RESP_OK 2'b00
`define IICC_RESP_ERR 2'b10

`endif

// ===== rtl/iicc_pkg.sv
// Types and helpers shared by the colour config block
package iicc_pkg;

  typedef enum logic [1:0] {IICC_YCC, IICC_RGB565, IICC_RGB888} iicc_fmt_type;

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic have_aw;
    logic [7:0] aw_addr;
    logic have_w;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] format;
    logic [31:0] conv;
    logic [31:0] ctrl;
    logic ovf;
    logic [15:0] pix_cnt;
    logic [2:0][7:0] d_s;
    logic [2:0] stb_s;
    logic [2:0] frm_s;
    logic stb_lvl;
    logic frm_lvl;
    logic [1:0] phase;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic push_v;
    logic [23:0] push_d;
    logic fresh;
  } iicc_st_type;

  function automatic logic [7:0] iicc_sat8(input logic signed [21:0] v);
    if (v < 0)
      return 8'h00;
    else if (v > 22'sd255)
      return 8'hff;
    else
      return v[7:0];
  endfunction

endpackage

// ===== rtl/iicc_fifo.sv
// Pixel word FIFO with a registered output stage
`timescale 1ns/1ps

module iicc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } iicc_fifo_st_type;

  iicc_fifo_st_type s, next_s;

  if (DEPTH < 2 || (2 ** AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("iicc_fifo: DEPTH must be a power of two, at least 2");
  end

  assign in_ready = (s.cnt != (AW + 1)'(DEPTH));
  assign out_data = s.od;
  assign out_valid = s.ov;
  assign level = s.cnt;

  always_comb begin
    next_s = s;
    if (in_valid && in_ready) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    // Output stage refills only from words already stored
    if ((!s.ov || out_ready) && s.cnt != '0) begin
      next_s.od = s.mem[s.rp];
      next_s.rp = s.rp + 1'b1;
      next_s.ov = 1'b1;
    end else if (out_ready) begin
      next_s.ov = 1'b0;
    end
    next_s.cnt = s.cnt + (AW + 1)'(in_valid && in_ready)
      - (AW + 1)'((!s.ov || out_ready) && s.cnt != '0);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s.cnt <= (AW + 1)'(DEPTH))
    else $error("fifo count above depth");

endmodule

// ===== rtl/iicc_top.sv
// Image input colour configuration: AXI4-Lite registers and pixel unpacking
`timescale 1ns/1ps
`include "iicc_map.svh"

// Functional notes
// RL1: Byte order field picks the RGB byte pattern only in RGB input mode.
// RL2: In RGB 8:8:8, order 0 means R-G-B, any other value B-G-R.
// RL3: Order 0: byte0 red plus green high, byte1 green low plus blue.
// RL4: Order 1: byte0 blue plus green high, byte1 green low plus red.
// RL5: Order 2: byte0 green low plus red, byte1 blue plus green high.
// RL6: Blue chroma offset bit set subtracts 16 from Cb, else none.
// RL7: Red chroma offset bit set subtracts 16 from Cr, else none.
// RL8: Luma offset bit set subtracts 128 from Y, else none.
// RL9: Coefficient four is unsigned 9-bit in steps of 1/128.
// RL10: Software avoids byte order 3; hardware treats it like order 0 in 5:6:5 and as B-G-R in 8:8:8.
// RL11: Width and height are 11-bit fields; format bit 27 reads zero.
module iicc_top import iicc_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pix_data,
  input wire logic pix_strobe,
  input wire logic pix_frame,
  output logic [23:0] px_out_data,
  output logic px_out_valid,
  input wire logic px_out_ready
);
  iicc_st_type s, next_s;
  logic fifo_in_ready;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  iicc_fmt_type fmt;
  logic [1:0] order;
  logic [7:0] cur;
  logic [23:0] pix;
  logic signed [11:0] yv;
  logic signed [11:0] cbv;
  logic signed [11:0] crv;
  logic signed [21:0] prod;
  logic take;
  logic drop;
  logic [1:0] last_phase;

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("iicc_top: FIFO_DEPTH must be at least 2");
  end

  iicc_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_data(s.push_d),
    .in_valid(s.push_v),
    .in_ready(fifo_in_ready),
    .out_data(px_out_data),
    .out_valid(px_out_valid),
    .out_ready(px_out_ready),
    .level(fifo_level)
  );

  assign s_axi_awready = s.aw_rdy;
  assign s_axi_wready = s.w_rdy;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.ar_rdy;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r & mask;
  endfunction

  // Pixel format from software configuration
  always_comb begin
    if (!s.format[`IICC_B_RGBSEL])
      fmt = IICC_YCC;
    else if (s.ctrl[`IICC_B_RGB888])
      fmt = IICC_RGB888;
    else
      fmt = IICC_RGB565;
    order = s.format[`IICC_F_ORDER];
    cur = s.d_s[2];
    last_phase = (fmt == IICC_RGB565) ? 2'd1 : 2'd2;
  end

  // Colour arithmetic for the byte that completes a pixel
  always_comb begin
    yv = $signed({4'h0, s.b0})
      - $signed(s.conv[`IICC_B_YOFF] ? `IICC_LUMA_OFS : 12'h000); // [RL8]
    cbv = $signed({4'h0, s.b1})
      - $signed(s.conv[`IICC_B_CBOFF] ? `IICC_CHROMA_OFS : 12'h000); // [RL6]
    crv = $signed({4'h0, cur})
      - $signed(s.conv[`IICC_B_CROFF] ? `IICC_CHROMA_OFS : 12'h000); // [RL7]
    prod = 22'(cbv * $signed({1'b0, s.conv[`IICC_F_C4]})); // [RL9]
    pix = '0;
    case (fmt)
      IICC_YCC: begin
        pix[23:16] = iicc_sat8(22'(yv) + 22'(crv));
        pix[15:8] = iicc_sat8(22'(yv));
        pix[7:0] = iicc_sat8(22'(yv) + (prod >>> `IICC_C4_SHIFT)); // [RL9]
      end
      IICC_RGB888: begin
        // Only RGB or BGR exist at three bytes per pixel
        if (order == 2'd0)
          pix = {s.b0, s.b1, cur}; // [RL2]
        else
          pix = {cur, s.b1, s.b0}; // [RL2]
      end
      IICC_RGB565: begin
        case (order) // [RL1]
          2'd1: begin
            pix[7:3] = s.b0[7:3]; // [RL4]
            pix[15:13] = s.b0[2:0];
            pix[12:10] = cur[7:5];
            pix[23:19] = cur[4:0];
          end
          2'd2: begin
            pix[12:10] = s.b0[7:5]; // [RL5]
            pix[23:19] = s.b0[4:0];
            pix[7:3] = cur[7:3];
            pix[15:13] = cur[2:0];
          end
          default: begin
            // Reserved order 3 falls back to the default pattern
            pix[23:19] = s.b0[7:3]; // [RL3] [RL10]
            pix[15:13] = s.b0[2:0];
            pix[12:10] = cur[7:5];
            pix[7:3] = cur[4:0];
          end
        endcase
        pix[18:16] = pix[23:21];
        pix[9:8] = pix[15:14];
        pix[2:0] = pix[7:5];
      end
      default: pix = '0;
    endcase
  end

  always_comb begin
    next_s = s;
    // Pin synchronisers; a level counts once stages two and three agree
    next_s.d_s = {s.d_s[1:0], pix_data};
    next_s.stb_s = {s.stb_s[1:0], pix_strobe};
    next_s.frm_s = {s.frm_s[1:0], pix_frame};
    if (s.stb_s[1] == s.stb_s[2])
      next_s.stb_lvl = s.stb_s[2];
    if (s.frm_s[1] == s.frm_s[2])
      next_s.frm_lvl = s.frm_s[2];
    take = s.stb_s[1] && s.stb_s[2] && !s.stb_lvl;
    drop = 1'b0;

    // Pixel assembly
    next_s.fresh = 1'b0;
    if (s.push_v && fifo_in_ready)
      next_s.push_v = 1'b0;
    if (!s.frm_lvl) begin
      next_s.phase = 2'd0;
    end else if (take) begin
      if (s.phase == 2'd0) begin
        next_s.b0 = cur;
        next_s.phase = 2'd1;
      end else if (s.phase != last_phase) begin
        next_s.b1 = cur;
        next_s.phase = 2'd2;
      end else begin
        next_s.phase = 2'd0;
        // Sensor cannot be stalled, so a blocked pixel is dropped
        if (next_s.push_v) begin
          drop = 1'b1;
          next_s.ovf = 1'b1;
        end else begin
          next_s.push_v = 1'b1;
          next_s.push_d = pix;
          next_s.fresh = 1'b1;
          next_s.b2 = cur;
          next_s.pix_cnt = s.pix_cnt + 16'h0001;
        end
      end
    end

    // Write channel
    if (s_axi_awvalid && s.aw_rdy && !s.have_aw) begin
      next_s.have_aw = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.w_rdy) begin
      next_s.have_w = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (s.have_aw && s.have_w && !s.bvalid) begin
      next_s.have_aw = 1'b0;
      next_s.have_w = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `IICC_RESP_OK;
      case ({s.aw_addr[7:2], 2'b00})
        `IICC_OFS_FORMAT:
          next_s.format = merge(s.format, s.wdata, s.wstrb,
                                `IICC_MASK_FORMAT); // [RL11]
        `IICC_OFS_CONV:
          next_s.conv = merge(s.conv, s.wdata, s.wstrb, `IICC_MASK_CONV);
        `IICC_OFS_CTRL:
          next_s.ctrl = merge(s.ctrl, s.wdata, s.wstrb, `IICC_MASK_CTRL);
        `IICC_OFS_STATUS: begin
          // New overflow in the same cycle beats the clear
          if (s.wstrb[2] && s.wdata[`IICC_B_OVF] && !drop)
            next_s.ovf = 1'b0;
        end
        default: next_s.bresp = `IICC_RESP_ERR;
      endcase
    end
    next_s.aw_rdy = !next_s.have_aw && !next_s.bvalid;
    // Data may arrive before or after its address
    next_s.w_rdy = !next_s.have_w && !next_s.bvalid;

    // Read channel
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s.ar_rdy) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `IICC_RESP_OK;
      case ({s_axi_araddr[7:2], 2'b00})
        `IICC_OFS_FORMAT: next_s.rdata = s.format;
        `IICC_OFS_CONV: next_s.rdata = s.conv;
        `IICC_OFS_CTRL: next_s.rdata = s.ctrl;
        `IICC_OFS_STATUS: begin
          next_s.rdata = {14'h0000, px_out_valid, s.ovf, s.pix_cnt};
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = `IICC_RESP_ERR;
        end
      endcase
    end
    next_s.ar_rdy = !next_s.rvalid;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.format <= `IICC_RST_FORMAT;
      s.conv <= `IICC_RST_CONV;
      s.ctrl <= `IICC_RST_CTRL;
    end else begin
      s <= next_s;
    end
  end

  // Checks on the design's own outputs
  rsvd_bit_zero_a: assert property ( // [RL11]
    @(posedge clk_sys) disable iff (sys_rst)
    s.rvalid && $past(s_axi_araddr) == `IICC_OFS_FORMAT
      && $rose(s.rvalid) |-> !s.rdata[`IICC_B_RSVD])
    else $error("format bit 27 read as one");

  order_zero_a: assert property ( // [RL3]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_RGB565 && order == 2'd0
      |-> s.push_d[23:19] == s.b0[7:3] && s.push_d[7:3] == s.b2[4:0])
    else $error("order 0 mapping wrong");

  order_one_a: assert property ( // [RL4]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_RGB565 && order == 2'd1
      |-> s.push_d[7:3] == s.b0[7:3] && s.push_d[23:19] == s.b2[4:0])
    else $error("order 1 mapping wrong");

  order_two_a: assert property ( // [RL5]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_RGB565 && order == 2'd2
      |-> s.push_d[23:19] == s.b0[4:0] && s.push_d[7:3] == s.b2[7:3])
    else $error("order 2 mapping wrong");

  rgb888_seq_a: assert property ( // [RL2]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_RGB888
      |-> s.push_d == ((order == 2'd0) ? {s.b0, s.b1, s.b2}
                                        : {s.b2, s.b1, s.b0}))
    else $error("8:8:8 sequence wrong");

  mode_gate_a: assert property ( // [RL1]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && !s.format[`IICC_B_RGBSEL] && !s.conv[`IICC_B_YOFF]
      |-> s.push_d[15:8] == s.b0)
    else $error("byte order used outside Rgb_input_select");

  luma_off_a: assert property ( // [RL8]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_YCC && s.conv[`IICC_B_YOFF] && s.b0 >= 8'h80
      |-> s.push_d[15:8] == s.b0 - 8'h80)
    else $error("luma offset wrong");

  cr_off_a: assert property ( // [RL7]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_YCC && !s.conv[`IICC_B_YOFF] && s.b0 == 8'h00
      && s.conv[`IICC_B_CROFF] && s.b2 >= 8'h10
      |-> s.push_d[23:16] == s.b2 - 8'h10)
    else $error("red chroma offset wrong");

  cb_off_a: assert property ( // [RL6]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_YCC && s.conv[`IICC_B_CBOFF] && s.b1 == 8'h10
      |-> s.push_d[7:0] == s.push_d[15:8])
    else $error("blue chroma offset wrong");

  coeff_step_a: assert property ( // [RL9]
    @(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_YCC && !s.conv[`IICC_B_YOFF] && s.b0 == 8'h00
      && !s.conv[`IICC_B_CBOFF]
      |-> s.push_d[7:0] == iicc_sat8(22'(({13'h0000, s.conv[`IICC_F_C4]}
                                          * {14'h0000, s.b1}) >> 7)))
    else $error("coefficient scaling wrong");

  write_resp_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s.have_aw && s.have_w && !s.bvalid |=> s.bvalid)
    else $error("write response missing");

  drop_when_full_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    drop |-> fifo_level == ($clog2(FIFO_DEPTH) + 1)'(FIFO_DEPTH))
    else $error("pixel dropped while fifo had room");

  cov_ycc: cover property (@(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_YCC);
  cov_rgb565: cover property (@(posedge clk_sys) disable iff (sys_rst)
    s.fresh && fmt == IICC_RGB565 && order == 2'd2);
  cov_overflow: cover property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(s.ovf));

endmodule

// ===== verif/iicc_sensor.sv
// Behavioural image sensor driving framed pixel bytes
`timescale 1ns/1ps

module iicc_sensor (
  input wire logic clk_sys,
  output logic [7:0] pix_data,
  output logic pix_strobe,
  output logic pix_frame
);
  initial begin
    pix_data = 8'h00;
    pix_strobe = 1'b0;
    pix_frame = 1'b0;
  end

  // Outside a frame the bus carries junk, never a stale byte
  always @(posedge clk_sys) begin
    if (!pix_frame) begin
      pix_data <= pix_data + 8'h5b;
    end
  end

  // Byte set up 2 cycles before the strobe rise, held 4 cycles after it
  task automatic send(input logic [7:0] b [3], input int n);
    repeat (2) @(posedge clk_sys);
    pix_frame <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      pix_data <= b[i];
      repeat (2) @(posedge clk_sys);
      pix_strobe <= 1'b1;
      repeat (4) @(posedge clk_sys);
      pix_strobe <= 1'b0;
      pix_data <= ~b[i];
      repeat (3) @(posedge clk_sys);
    end
    pix_frame <= 1'b0;
  endtask
endmodule

// ===== verif/iicc_tb_top.sv
// Self-checking bench: AXI4-Lite register traffic and pixel unpacking
`timescale 1ns/1ps

module iicc_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, px_out_ready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, pix_strobe, pix_frame, px_out_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] pix_data;
  logic [23:0] px_out_data;
  logic [33:0] pq[$], rq[$], bq[$];
  logic [31:0] rm[$];
  logic stall = 1'b0;
  bit yo, cbo, cro;
  int c4v;
  int miscompares = 0;
  int total_checks = 0;

  iicc_top #(.FIFO_DEPTH(8)) u_dut (
    .clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pix_data, .pix_strobe, .pix_frame,
    .px_out_data, .px_out_valid, .px_out_ready
  );

  iicc_sensor u_sen (.clk_sys, .pix_data, .pix_strobe, .pix_frame);

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // Random back-pressure on the pixel output unless a test stalls it
  always @(posedge clk_sys) begin
    px_out_ready <= !stall && ($urandom_range(3) != 0);
  end

  task automatic chk(input string nm, input logic [33:0] e, g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h got %h", nm, e, g);
    end
  endtask

  always @(posedge clk_sys) begin
    if (s_axi_bvalid && s_axi_bready) begin
      chk("bresp", bq.pop_front(), {32'h0, s_axi_bresp});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata & rm.pop_front()});
    end
    if (px_out_valid && px_out_ready) begin
      chk("pixel", pq.pop_front(), {10'h0, px_out_data});
    end
  end

  task automatic close_out();
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'b00);
    bit ad = 0;
    bit wd = 0;
    bq.push_back({32'h0, r});
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    rq.push_back(e);
    rm.push_back(m);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [7:0] sat(input int v);
    return v < 0 ? 8'h00 : (v > 255 ? 8'hff : v[7:0]);
  endfunction

  function automatic logic [23:0] ycc(input int y, cb, cr);
    int a, c, r;
    a = y - (yo ? 128 : 0);
    c = cb - (cbo ? 16 : 0);
    r = cr - (cro ? 16 : 0);
    return {sat(a + r), sat(a), sat(a + ((c4v * c) >>> 7))};
  endfunction

  // Mode 0 luma/chroma, 1 packed 5:6:5, 2 full 8:8:8
  task automatic px(input int md, input logic [1:0] o,
                    input logic [7:0] x, y, z, input bit keep = 1);
    logic [7:0] b [3];
    logic [23:0] e;
    int n;
    n = (md == 1) ? 2 : 3;
    e = {x, y, z};
    if (md == 0) begin
      b = '{x, y, z};
      e = ycc(x, y, z);
    end else if (md == 2 && o == 2'd0) begin
      b = '{x, y, z};
    end else if (md == 2) begin
      b = '{z, y, x};
    end else begin
      e = {x[7:3], x[7:5], y[7:2], y[7:6], z[7:3], z[7:5]};
      case (o)
        2'd0: b = '{{x[7:3], y[7:5]}, {y[4:2], z[7:3]}, 8'h00};
        2'd1: b = '{{z[7:3], y[7:5]}, {y[4:2], x[7:3]}, 8'h00};
        default: b = '{{y[4:2], x[7:3]}, {z[7:3], y[7:5]}, 8'h00};
      endcase
    end
    if (keep) begin
      pq.push_back({10'h0, e});
    end
    u_sen.send(b, n);
  endtask

  // Drain first so no pixel in flight sees the new setting
  task automatic cfg(input logic [31:0] f, c, v);
    while (pq.size() != 0) @(posedge clk_sys);
    {cbo, cro, yo} = v[14:12];
    c4v = v[8:0];
    wr(8'h04, f);
    wr(8'h20, c);
    wr(8'h14, v);
  endtask

  initial begin
    void'($urandom(29914));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(8'h04, 34'h0);
    rd(8'h14, 34'h7102);
    rd(8'h20, 34'h0);
    rd(8'h30, {2'b10, 32'h0});
    wr(8'h30, 32'h1, 2'b10);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, 34'hf7ff_ffff);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 34'h71ff);
    // Byte order 3 is never set for the pixel tests
    for (int o = 0; o < 3; o++) begin
      for (int md = 1; md < 3; md++) begin
        cfg({o[1:0], 30'h1000}, md - 1, 32'h7102);
        repeat (3) begin
          px(md, o[1:0], 8'($urandom), 8'($urandom), 8'($urandom));
        end
      end
    end
    for (int k = 0; k < 8; k++) begin
      cfg(32'h4000_0000, 32'h0,
          {17'h0, k[2:0], 3'h0, k == 7 ? 9'h1ff : 9'($urandom)});
      px(0, 2'd1, 8'($urandom), 8'($urandom), 8'($urandom));
      px(0, 2'd1, 8'h00, 8'h10, 8'($urandom) | 8'h10);
    end
    cfg(32'h0000_1000, 32'h1, 32'h0);
    stall <= 1'b1;
    // Output stage and 8 words hold 9, the 10th waits, the 11th is lost
    for (int k = 0; k < 11; k++) begin
      px(2, 2'd0, 8'(k), 8'(k * 3), 8'(255 - k), k < 10);
    end
    rd(8'h24, 34'h3_0000, 32'h3_0000);
    wr(8'h24, 32'h1_0000);
    rd(8'h24, 34'h2_0000, 32'h3_0000);
    stall <= 1'b0;
    cfg(32'h0, 32'h0, 32'h7102);
    rd(8'h24, 34'h0, 32'h3_0000);
    close_out();
  end

  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
